// ==== common/ext_bus_defs.vh ====
/*
 * Constants of the external bus wait-state and arbitration logic:
 * register offsets, field positions, reset values and the bus period scale.
 * Assumes it is included by bare name from design files.
 */
`ifndef EXT_BUS_DEFS_VH
`define EXT_BUS_DEFS_VH

// Register byte offsets on the Avalon-MM slave
`define EB_OFS_CTRL        4'h0
`define EB_OFS_TIMING      4'h4
`define EB_OFS_STATUS      4'h8

// Control register fields
`define EB_CTRL_RDY_EN     0
`define EB_CTRL_RDY_POL    1
`define EB_CTRL_RDY_ASYNC  2
`define EB_CTRL_ARB_EN     3
`define EB_CTRL_RST        4'h0

// Timing register fields (lengths in bus clock periods)
`define EB_TIM_AB          0
`define EB_TIM_C_LO        1
`define EB_TIM_C_HI        2
`define EB_TIM_D           3
`define EB_TIM_E_LO        4
`define EB_TIM_E_HI        8
`define EB_TIM_F_LO        9
`define EB_TIM_F_HI        10
`define EB_TIM_RST         11'h000

// Status register fields
`define EB_STA_STATE_LO    0
`define EB_STA_STATE_HI    3
`define EB_STA_RELEASED    4
`define EB_STA_HOLD        5
`define EB_STA_WAIT_LO     8
`define EB_STA_WAIT_HI     15

// System clock cycles per bus clock period
`define EB_SYS_PER_TCS     2

`endif

// ==== logic/ext_bus_ready_arb.v ====
/*
 * External bus controller: phase sequencer with ready-controlled wait
 * states and bus release/regain arbitration, plus an Avalon-MM slave
 * holding control, timing and status.
 * Assumes one system clock; ready, hold and read data arrive from pins
 * and are synchronised here; the requester keeps its request up until
 * the done pulse and drops it in the cycle after.
 */
`include "ext_bus_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module ext_bus_ready_arb #(
   parameter AW = 16,
   parameter DW = 16
) (
   input  wire          i_sys_clk,
   input  wire          i_nrst,
   // Avalon-MM register slave
   input  wire [3:0]    i_avs_address,
   input  wire          i_avs_read,
   input  wire          i_avs_write,
   input  wire [31:0]   i_avs_writedata,
   output reg  [31:0]   o_avs_readdata,
   output reg           o_avs_waitrequest,
   // Internal access requests
   input  wire          i_req,
   input  wire          i_req_wr,
   input  wire [AW-1:0] i_req_addr,
   input  wire [DW-1:0] i_req_wdata,
   output reg           o_req_done,
   output reg  [DW-1:0] o_req_rdata,
   // External bus pins
   output reg           o_reference_clock_output,
   output reg           o_ale,
   output reg           o_rd_n,
   output reg           o_wr_n,
   output reg           o_ctrl_oe,
   output reg  [AW-1:0] o_addr,
   output reg           o_addr_oe,
   output reg  [DW-1:0] o_data_out,
   output reg           o_data_oe,
   input  wire [DW-1:0] i_data_in,
   input  wire          i_ready,
   input  wire          i_hold_n,
   output reg           o_release_acknowledge_n,
   output reg           o_regain_request_out_n
);

   localparam [3:0] S_IDLE     = 4'h0;
   localparam [3:0] S_AB       = 4'h1;
   localparam [3:0] S_C        = 4'h2;
   localparam [3:0] S_D        = 4'h3;
   localparam [3:0] S_E        = 4'h4;
   localparam [3:0] S_RDY      = 4'h5;
   localparam [3:0] S_F        = 4'h6;
   localparam [3:0] S_REL_DRV  = 4'h7;
   localparam [3:0] S_RELEASED = 4'h8;
   localparam [3:0] S_REG_FLT  = 4'h9;
   localparam [3:0] S_REG_DRV  = 4'ha;

   reg  [3:0]    ctrl;
   reg  [10:0]   timing;
   reg  [3:0]    state;
   reg  [4:0]    cnt;
   reg  [7:0]    wait_cnt;
   reg           cyc_wr;
   reg           rdy_s1;
   reg           rdy_s2;
   reg           rdy_s3;
   reg           hold_s1;
   reg           hold_s2;
   reg  [DW-1:0] data_s1;
   reg  [DW-1:0] data_s2;

   wire       rdy_en    = ctrl[`EB_CTRL_RDY_EN];
   wire       rdy_pol   = ctrl[`EB_CTRL_RDY_POL];
   wire       rdy_async = ctrl[`EB_CTRL_RDY_ASYNC];
   wire       arb_en    = ctrl[`EB_CTRL_ARB_EN];
   wire       len_ab    = timing[`EB_TIM_AB];
   wire [1:0] len_c     = timing[`EB_TIM_C_HI:`EB_TIM_C_LO];
   wire       len_d     = timing[`EB_TIM_D];
   wire [4:0] len_e     = timing[`EB_TIM_E_HI:`EB_TIM_E_LO];
   wire [1:0] len_f     = timing[`EB_TIM_F_HI:`EB_TIM_F_LO];

   // Bus clock period ends on the edge where the reference clock falls
   wire tick = o_reference_clock_output;

   // Ready sample: polarity chosen, extra stage in asynchronous mode
   wire rdy_smp  = rdy_async ? rdy_s3 : rdy_s2;
   wire rdy_act  = (rdy_smp == rdy_pol);
   wire hold_req = arb_en & ~hold_s2;

   // Length test shared by the phase counters
   function last_period;
      input [4:0] c;
      begin
         last_period = (c == 5'h00);
      end
   endfunction

   // Pin synchronisers; the first stage feeds only the second
   always @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         rdy_s1  <= 1'b0;
         rdy_s2  <= 1'b0;
         rdy_s3  <= 1'b0;
         hold_s1 <= 1'b1;
         hold_s2 <= 1'b1;
         data_s1 <= {DW{1'b0}};
         data_s2 <= {DW{1'b0}};
      end else begin
         rdy_s1  <= i_ready;
         rdy_s2  <= rdy_s1;
         rdy_s3  <= rdy_s2;
         hold_s1 <= i_hold_n;
         hold_s2 <= hold_s1;
         data_s1 <= i_data_in;
         data_s2 <= data_s1;
      end
   end

   // Avalon-MM slave: one wait cycle, then a single answer cycle
   always @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata    <= 32'h00000000;
         ctrl              <= `EB_CTRL_RST;
         timing            <= `EB_TIM_RST;
      end else begin
         if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
            o_avs_waitrequest <= 1'b0;
         end else begin
            o_avs_waitrequest <= 1'b1;
         end
         if (i_avs_read && o_avs_waitrequest) begin
            case (i_avs_address)
               `EB_OFS_CTRL:   o_avs_readdata <= {28'h0000000, ctrl};
               `EB_OFS_TIMING: o_avs_readdata <= {21'h00000, timing};
               `EB_OFS_STATUS: o_avs_readdata <= {16'h0000, wait_cnt,
                                  2'b00, hold_req,
                                  (state == S_RELEASED), state};
               default:        o_avs_readdata <= 32'h00000000;
            endcase
         end
         if (i_avs_write && !o_avs_waitrequest) begin
            case (i_avs_address)
               `EB_OFS_CTRL:   ctrl   <= i_avs_writedata[3:0];
               `EB_OFS_TIMING: timing <= i_avs_writedata[10:0];
               default:        ctrl   <= ctrl;
            endcase
         end
      end
   end

   // Phase sequencer and arbitration, advancing once per bus period
   always @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         o_reference_clock_output <= 1'b0;
         state                    <= S_IDLE;
         cnt                      <= 5'h00;
         wait_cnt                 <= 8'h00;
         cyc_wr                   <= 1'b0;
         o_req_done               <= 1'b0;
         o_req_rdata              <= {DW{1'b0}};
         o_ale                    <= 1'b0;
         o_rd_n                   <= 1'b1;
         o_wr_n                   <= 1'b1;
         o_ctrl_oe                <= 1'b1;
         o_addr                   <= {AW{1'b0}};
         o_addr_oe                <= 1'b1;
         o_data_out               <= {DW{1'b0}};
         o_data_oe                <= 1'b0;
         o_release_acknowledge_n  <= 1'b1;
         o_regain_request_out_n   <= 1'b1;
      end else begin
         o_reference_clock_output <= ~o_reference_clock_output;
         o_req_done               <= 1'b0;
         if (tick) begin
            case (state)
               S_IDLE: begin
                  if (hold_req) begin
                     state <= S_REL_DRV;
                     o_ale <= 1'b0;
                  end else if (i_req) begin
                     state      <= S_AB;
                     cnt        <= {4'h0, len_ab};
                     cyc_wr     <= i_req_wr;
                     o_addr     <= i_req_addr;
                     o_data_out <= i_req_wdata;
                     o_ale      <= 1'b1;
                     wait_cnt   <= 8'h00;
                  end
               end
               S_AB: begin
                  if (last_period(cnt)) begin
                     o_ale <= 1'b0;
                     if (len_c != 2'b00) begin
                        state <= S_C;
                        cnt   <= {3'h0, len_c} - 5'h01;
                     end else if (len_d) begin
                        state     <= S_D;
                        o_data_oe <= cyc_wr;
                     end else begin
                        state     <= S_E;
                        cnt       <= len_e;
                        o_data_oe <= cyc_wr;
                        o_rd_n    <= cyc_wr;
                        o_wr_n    <= ~cyc_wr;
                     end
                  end else begin
                     cnt <= cnt - 5'h01;
                  end
               end
               S_C: begin
                  if (last_period(cnt)) begin
                     o_data_oe <= cyc_wr;
                     if (len_d) begin
                        state <= S_D;
                     end else begin
                        state  <= S_E;
                        cnt    <= len_e;
                        o_rd_n <= cyc_wr;
                        o_wr_n <= ~cyc_wr;
                     end
                  end else begin
                     cnt <= cnt - 5'h01;
                  end
               end
               S_D: begin
                  state  <= S_E;
                  cnt    <= len_e;
                  o_rd_n <= cyc_wr;
                  o_wr_n <= ~cyc_wr;
               end
               S_E: begin
                  // Synchronous mode samples first at the end of the programmed access
                  if (!last_period(cnt)) begin
                     cnt <= cnt - 5'h01;
                  end else if (rdy_en && (rdy_async || !rdy_act)) begin
                     state <= S_RDY;
                  end else begin
                     state       <= (len_f != 2'b00) ? S_F : S_IDLE;
                     cnt         <= {3'h0, len_f} - 5'h01;
                     o_rd_n      <= 1'b1;
                     o_wr_n      <= 1'b1;
                     o_data_oe   <= 1'b0;
                     o_req_rdata <= cyc_wr ? o_req_rdata : data_s2;
                     o_req_done  <= 1'b1;
                  end
               end
               S_RDY: begin
                  if (rdy_act) begin
                     state       <= (len_f != 2'b00) ? S_F : S_IDLE;
                     cnt         <= {3'h0, len_f} - 5'h01;
                     o_rd_n      <= 1'b1;
                     o_wr_n      <= 1'b1;
                     o_data_oe   <= 1'b0;
                     o_req_rdata <= cyc_wr ? o_req_rdata : data_s2;
                     o_req_done  <= 1'b1;
                  end else if (wait_cnt != 8'hff) begin
                     wait_cnt <= wait_cnt + 8'h01;
                  end
               end
               S_F: begin
                  if (last_period(cnt)) begin
                     state <= S_IDLE;
                  end else begin
                     cnt <= cnt - 5'h01;
                  end
               end
               S_REL_DRV: begin
                  // Controls were driven inactive; now let them float
                  state                   <= S_RELEASED;
                  o_ctrl_oe               <= 1'b0;
                  o_addr_oe               <= 1'b0;
                  o_release_acknowledge_n <= 1'b0;
               end
               S_RELEASED: begin
                  if (hold_s2 || !arb_en) begin
                     state                   <= S_REG_FLT;
                     o_release_acknowledge_n <= 1'b1;
                     o_regain_request_out_n  <= 1'b1;
                  end else begin
                     // Held requests only ask for the bus back
                     o_regain_request_out_n <= ~i_req;
                  end
               end
               S_REG_FLT: begin
                  state     <= S_REG_DRV;
                  o_ctrl_oe <= 1'b1;
                  o_addr_oe <= 1'b1;
                  o_ale     <= 1'b0;
               end
               S_REG_DRV: begin
                  state <= S_IDLE;
               end
               default: begin
                  state <= S_IDLE;
               end
            endcase
         end
      end
   end

endmodule // ext_bus_ready_arb

`default_nettype wire

// ==== testbench/ext_bus_monitor.sv ====
/* Checker of strobes, release and regain at the controller's pins.
   Assumes it is bound onto ext_bus_ready_arb and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module ext_bus_monitor (
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic o_avs_waitrequest,
   input wire logic o_req_done,
   input wire logic o_ale,
   input wire logic o_rd_n,
   input wire logic o_wr_n,
   input wire logic o_ctrl_oe,
   input wire logic o_addr_oe,
   input wire logic o_release_acknowledge_n,
   input wire logic o_regain_request_out_n
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);
   // Register bus answers one cycle after the request
   property p_bus_ack;
      (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
   endproperty
   a_bus_ack: assert property (p_bus_ack) else $error("no bus answer");
   // Done only where the command strobe rises
   property p_done;
      o_req_done |-> o_rd_n && o_wr_n && !$past(o_rd_n && o_wr_n);
   endproperty
   a_done: assert property (p_done)
      else $error("done off strobe");
   // Latch strobe low while floated
   property p_float_ale;
      !o_ctrl_oe |-> !o_ale;
   endproperty
   a_float_ale: assert property (p_float_ale)
      else $error("ale floated");
   // Controls inactive just before floating
   property p_drv_first;
      $fell(o_ctrl_oe) |-> $past(o_rd_n && o_wr_n && !o_ale);
   endproperty
   a_drv_first: assert property (p_drv_first)
      else $error("float early");
   // Acknowledge low only while pins float
   property p_ack_float;
      !o_release_acknowledge_n |-> !o_ctrl_oe && !o_addr_oe;
   endproperty
   a_ack_float: assert property (p_ack_float)
      else $error("ack driven");
   // Release only after an idle driven stage
   property p_ack_after;
      $fell(o_release_acknowledge_n) |-> $past(o_ctrl_oe && o_rd_n && o_wr_n, 2);
   endproperty
   a_ack_after: assert property (p_ack_after)
      else $error("early grant");
   // Regain request only once released
   property p_regain_req;
      !o_regain_request_out_n |-> !o_release_acknowledge_n;
   endproperty
   a_regain_req: assert property (p_regain_req)
      else $error("early regain");
   // No cycle activity while released
   property p_no_cycle;
      !o_release_acknowledge_n |-> !o_ale && o_rd_n && o_wr_n && !o_req_done;
   endproperty
   a_no_cycle: assert property (p_no_cycle)
      else $error("cycle released");
   // Regain drives inactive levels before any new cycle
   property p_regain_seq;
      $rose(o_ctrl_oe) |-> $past(o_release_acknowledge_n) &&
         (!o_ale && o_rd_n && o_wr_n) [*3];
   endproperty
   a_regain_seq: assert property (p_regain_seq)
      else $error("bad regain");
endmodule // ext_bus_monitor

bind ext_bus_ready_arb ext_bus_monitor u_mon (.i_sys_clk, .i_nrst, .i_avs_read,
   .i_avs_write, .o_avs_waitrequest, .o_req_done, .o_ale, .o_rd_n, .o_wr_n,
   .o_ctrl_oe, .o_addr_oe, .o_release_acknowledge_n, .o_regain_request_out_n);
`default_nettype wire

// ==== testbench/ext_bus_partner.sv ====
/* Far-side memory model: answers command strobes with ready and data.
   Assumes it is clocked by the controller's reference clock output. */
`timescale 1ns/1ps
`default_nettype none
module ext_bus_partner (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rd_n,
   input  wire logic        i_wr_n,
   input  wire logic        i_pol,
   input  wire logic [3:0]  i_delay,
   input  wire logic [15:0] i_rdata,
   output logic             o_ready,
   output logic [15:0]      o_data
);
   logic [3:0] ticks = 4'h0;
   // Reference periods with a strobe low, cleared when it rises
   always @(posedge i_ref_clk) begin
      if (i_rd_n && i_wr_n)
         ticks <= 4'h0;
      else if (ticks != 4'hf)
         ticks <= ticks + 4'h1;
   end
   // Ready held until the strobe rises, then dropped at once
   assign o_ready = ~(((ticks >= i_delay) && !(i_rd_n && i_wr_n)) ^
                      i_pol);
   // Data only while read strobe low, otherwise a changed pattern
   assign o_data = i_rd_n ? ~i_rdata : i_rdata;
endmodule // ext_bus_partner
`default_nettype wire

// ==== testbench/tb_top.sv ====
/* Self-checking bench of the external bus ready and release logic.
   Assumes the partner model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
   $display("CHECK FAILED at %0t: %0h vs %0h", $time, a, b); end end
`define WAITF(c) begin for (n = 0; n < 600 && !(c); n++) \
   @(posedge i_sys_clk); \
   if (n == 600) begin miscompares++; report_and_stop; end end
module tb_top;
   typedef struct {logic [3:0] ctl; logic [10:0] tim; logic wr;
      logic [3:0] dly; int lo; int hi;} row_t;
   logic        i_sys_clk = 1'b0;
   logic        i_nrst = 1'b0;
   logic [3:0]  i_avs_address = 4'h0;
   logic        i_avs_read = 1'b0;
   logic        i_avs_write = 1'b0;
   logic [31:0] i_avs_writedata = 32'h0;
   logic        i_req = 1'b0;
   logic        i_req_wr = 1'b0;
   logic [15:0] i_req_addr = 16'h0;
   logic [15:0] i_req_wdata = 16'h0;
   logic        i_hold_n = 1'b1;
   logic        pol = 1'b1;
   logic [3:0]  delay = 4'h0;
   logic [15:0] pattern = 16'h0;
   logic [31:0] rd;
   int          miscompares = 0;
   int          tests_run = 0;
   int          n;
   int          cyc;
   wire         o_avs_waitrequest, o_req_done, o_reference_clock_output;
   wire         o_ale, o_rd_n, o_wr_n, o_ctrl_oe, o_addr_oe, o_data_oe;
   wire         i_ready, o_release_acknowledge_n, o_regain_request_out_n;
   wire [15:0]  o_req_rdata, o_addr, o_data_out, i_data_in;
   wire [31:0]  o_avs_readdata;
   // Bus timing cases and their lengths in bus periods; the shortest
   // access runs as a write, as read data lag two synchroniser stages
   row_t rows [6] = '{'{4'h0, 11'h000, 1'b1, 4'h0, 2, 2},
      '{4'h0, 11'h7ff, 1'b0, 4'h0, 38, 38}, '{4'h3, 11'h030, 1'b0, 4'h0, 5, 5},
      '{4'h1, 11'h030, 1'b0, 4'h0, 5, 5}, '{4'h7, 11'h030, 1'b0, 4'h0, 6, 6},
      '{4'h3, 11'h030, 1'b0, 4'h8, 6, 15}};

   ext_bus_ready_arb u_dut (.i_sys_clk, .i_nrst, .i_avs_address, .i_avs_read,
      .i_avs_write, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest,
      .i_req, .i_req_wr, .i_req_addr, .i_req_wdata, .o_req_done, .o_req_rdata,
      .o_reference_clock_output, .o_ale, .o_rd_n, .o_wr_n, .o_ctrl_oe,
      .o_addr, .o_addr_oe, .o_data_out, .o_data_oe, .i_data_in, .i_ready,
      .i_hold_n, .o_release_acknowledge_n, .o_regain_request_out_n);
   ext_bus_partner u_far (.i_ref_clk(o_reference_clock_output),
      .i_rd_n(o_rd_n), .i_wr_n(o_wr_n), .i_pol(pol), .i_delay(delay),
      .i_rdata(pattern), .o_ready(i_ready), .o_data(i_data_in));

   // 125 MHz system clock
   always #4 i_sys_clk = ~i_sys_clk;

   // Counts, verdict and end of run
   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // One register access held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] d);
      @(posedge i_sys_clk);
      i_avs_address <= a;
      i_avs_write <= wr;
      i_avs_read <= !wr;
      i_avs_writedata <= d;
      `WAITF(!o_avs_waitrequest)
      rd = o_avs_readdata;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
   endtask

   // One internal access; cycles from latch strobe to done into cyc
   task automatic run(input logic wr);
      @(posedge i_sys_clk);
      i_req_wr <= wr;
      i_req_addr <= ~pattern;
      i_req_wdata <= pattern;
      i_req <= 1'b1;
      `WAITF(o_ale)
      `CHK({o_addr, o_data_out}, {~pattern, pattern})
      for (cyc = 0; cyc < 600 && !o_req_done; cyc++) @(posedge i_sys_clk);
      if (cyc == 600) begin
         miscompares++;
         report_and_stop;
      end
      i_req <= 1'b0;
   endtask

   initial begin
      repeat (4) @(posedge i_sys_clk);
      i_nrst <= 1'b1;
      // Reset values, unmapped write ignored
      bus(1'b1, 4'hc, 32'hffffffff);
      for (int a = 0; a < 16; a += 4) begin
         bus(1'b0, 4'(a), 32'h0);
         `CHK(rd & (a == 8 ? 32'h3f : 32'hffffffff), 32'h0)
      end
      // Timing and ready cases from the table
      foreach (rows[k]) begin
         bus(1'b1, 4'h0, {28'h0, rows[k].ctl});
         bus(1'b1, 4'h4, {21'h0, rows[k].tim});
         pol <= rows[k].ctl[1];
         delay <= rows[k].dly;
         pattern <= 16'ha5c0 + 16'(k);
         run(rows[k].wr);
         `CHK(cyc >= 2 * rows[k].lo, 1'b1)
         `CHK(cyc <= 2 * rows[k].hi, 1'b1)
         if (!rows[k].wr)
            `CHK(o_req_rdata, 16'ha5c0 + 16'(k))
      end
      // Last row: ready comes eight periods late, four resamples counted
      bus(1'b0, 4'h8, 32'h0);
      `CHK(rd[15:8], 8'h04)
      // Hold request ignored with arbitration off
      i_hold_n <= 1'b0;
      repeat (20) @(posedge i_sys_clk);
      `CHK({o_release_acknowledge_n, o_ctrl_oe}, 2'b11)
      i_hold_n <= 1'b1;
      // Hold arrives in mid-cycle; cycle finishes first
      bus(1'b1, 4'h0, 32'h8);
      bus(1'b1, 4'h4, 32'h7ff);
      @(posedge i_sys_clk);
      i_req_wr <= 1'b0;
      i_req <= 1'b1;
      `WAITF(o_ale)
      i_hold_n <= 1'b0;
      `WAITF(o_req_done)
      i_req <= 1'b0;
      `CHK(o_release_acknowledge_n, 1'b1)
      `WAITF(!o_release_acknowledge_n)
      `CHK({o_ctrl_oe, o_addr_oe}, 2'b00)
      // Pending request while released asks for the bus back
      i_req <= 1'b1;
      repeat (10) @(posedge i_sys_clk);
      `CHK(o_regain_request_out_n, 1'b0)
      `CHK({o_release_acknowledge_n, o_ale}, 2'b00)
      i_hold_n <= 1'b1;
      `WAITF(o_release_acknowledge_n)
      `CHK(o_ctrl_oe, 1'b0)
      `WAITF(o_req_done)
      i_req <= 1'b0;
      `CHK(o_ctrl_oe, 1'b1)
      // Other master gives back the bus unasked
      i_hold_n <= 1'b0;
      `WAITF(!o_release_acknowledge_n)
      repeat (6) @(posedge i_sys_clk);
      `CHK(o_regain_request_out_n, 1'b1)
      i_hold_n <= 1'b1;
      `WAITF(o_ctrl_oe)
      `CHK(o_release_acknowledge_n, 1'b1)
      // Mid-run reset returns pins and registers to idle
      repeat (4) @(posedge i_sys_clk);
      i_nrst <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
      i_nrst <= 1'b1;
      @(posedge i_sys_clk);
      `CHK({o_release_acknowledge_n, o_regain_request_out_n, o_ctrl_oe, o_ale}, 4'he)
      bus(1'b0, 4'h0, 32'h0);
      `CHK(rd, 32'h0)
      report_and_stop;
   end
endmodule // tb_top
`default_nettype wire
